// *** src/ftl_pkg.sv ***
// Purpose: shared constants and carriers for the full-to-lite bridge
// Assumes: upstream data at least as wide as the lite side
// Notes: lite side fixed at 32 bits
package ftl_pkg;
	// bus widths
	localparam int ID_W     = 4;
	localparam int ADDR_W   = 32;
	localparam int UP_DW    = 64;
	localparam int LT_DW    = 32;
	localparam int LT_SW    = LT_DW / 8;
	localparam int LANES    = UP_DW / LT_DW;
	localparam int LANE_LSB = $clog2(LT_SW);
	localparam int LANE_W   = (LANES > 1) ? $clog2(LANES) : 1;
	localparam int Q_DEPTH  = 2;
	localparam logic [2:0] LT_SIZE = 3'(LANE_LSB);
	// burst lengths and types
	localparam logic [7:0] LEN_SINGLE  = 8'h00;
	localparam logic [7:0] LEN_STEP    = 8'h01;
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_WRAP  = 2'h2;
	// responses and attributes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         RESP_ERR    = 1;
	localparam logic [3:0] CACHE_LITE  = 4'h0;
	// operating modes
	typedef enum logic [1:0] {
		FTL_CONVERT = 2'b00,
		FTL_SIMPLE  = 2'b01,
		FTL_PROTECT = 2'b10,
		FTL_DETECT  = 2'b11
	} ftl_mode_t;
	// upstream address request
	typedef struct packed {
		logic [ID_W-1:0]   id;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        len;
		logic [2:0]        size;
		logic [1:0]        burst;
		logic              lock;
		logic [3:0]        cache;
		logic [2:0]        prot;
	} ftl_areq_t;
	// upstream write beat
	typedef struct packed {
		logic [UP_DW-1:0]   data;
		logic [UP_DW/8-1:0] strb;
		logic               last;
	} ftl_wbeat_t;
	// lite address request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [2:0]        prot;
	} ftl_laddr_t;
endpackage : ftl_pkg

// *** src/ftl_id_queue.sv ***
// Purpose: in-order queue of transaction ids
// Assumes: push and pop on the same clock
// Notes: push when full and pop when empty are ignored
`timescale 1ns/100ps
module ftl_id_queue #(
	parameter int DEPTH = ftl_pkg::Q_DEPTH,
	parameter int W     = ftl_pkg::ID_W
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// fill side
	input  wire logic         push,
	input  wire logic [W-1:0] push_id,
	output logic              full,
	// drain side
	input  wire logic         pop,
	output logic [W-1:0]      head
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0]  slot [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic          do_push;
	logic          do_pop;
	// guarded strobes and status
	assign do_push = push && !full;
	assign do_pop  = pop && (count != '0);
	assign full    = (count == CW'(DEPTH));
	assign head    = slot[rd_ptr];
	// pointer wrap
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction : bump
	// storage and pointers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				slot[i] <= '0;
			end
		end else begin
			if (do_push) begin
				slot[wr_ptr] <= push_id;
				wr_ptr       <= bump(wr_ptr);
			end
			if (do_pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule : ftl_id_queue

// *** src/ftl_resp_merge.sv ***
// Purpose: fold one lite response into a running result
// Assumes: first marks the opening response of a group
// Notes: purely combinational
`timescale 1ns/100ps
module ftl_resp_merge (
	// group control
	input  wire logic       first,
	// responses
	input  wire logic [1:0] acc,
	input  wire logic [1:0] incoming,
	output logic [1:0]      merged
);
	logic [1:0] clean;
	assign clean  = (incoming == ftl_pkg::RESP_EXOKAY) ? ftl_pkg::RESP_OKAY : incoming;
	assign merged = (first || !acc[ftl_pkg::RESP_ERR]) ? clean : acc;
endmodule : ftl_resp_merge

// *** src/ftl_bridge.sv ***
// Purpose: full-protocol master to 32-bit lite slave converter
// Assumes: mode held steady while transactions are open
// Notes: one transaction per direction in flight
`timescale 1ns/100ps
module ftl_bridge (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	// mode and detection
	input  wire ftl_pkg::ftl_mode_t   mode,
	output logic                      nc_flag,
	// upstream write address
	input  wire logic                 s_awvalid,
	output logic                      s_awready,
	input  wire ftl_pkg::ftl_areq_t   s_aw,
	// upstream write data
	input  wire logic                 s_wvalid,
	output logic                      s_wready,
	input  wire ftl_pkg::ftl_wbeat_t  s_w,
	// upstream write response
	output logic                      s_bvalid,
	input  wire logic                 s_bready,
	output logic [ftl_pkg::ID_W-1:0]  s_bid,
	output logic [1:0]                s_bresp,
	// upstream read address
	input  wire logic                 s_arvalid,
	output logic                      s_arready,
	input  wire ftl_pkg::ftl_areq_t   s_ar,
	// upstream read data
	output logic                      s_rvalid,
	input  wire logic                 s_rready,
	output logic [ftl_pkg::ID_W-1:0]  s_rid,
	output logic [ftl_pkg::UP_DW-1:0] s_rdata,
	output logic [1:0]                s_rresp,
	output logic                      s_rlast,
	// lite write
	output logic                      m_awvalid,
	input  wire logic                 m_awready,
	output ftl_pkg::ftl_laddr_t       m_aw,
	output logic                      m_wvalid,
	input  wire logic                 m_wready,
	output logic [ftl_pkg::LT_DW-1:0] m_wdata,
	output logic [ftl_pkg::LT_SW-1:0] m_wstrb,
	input  wire logic                 m_bvalid,
	output logic                      m_bready,
	input  wire logic [1:0]           m_bresp,
	// lite read
	output logic                      m_arvalid,
	input  wire logic                 m_arready,
	output ftl_pkg::ftl_laddr_t       m_ar,
	input  wire logic                 m_rvalid,
	output logic                      m_rready,
	input  wire logic [ftl_pkg::LT_DW-1:0] m_rdata,
	input  wire logic [1:0]           m_rresp
);
	localparam int AW  = ftl_pkg::ADDR_W;
	localparam int LDW = ftl_pkg::LT_DW;
	localparam int LSW = ftl_pkg::LT_SW;
	localparam int LSB = ftl_pkg::LANE_LSB;
	localparam int LW  = ftl_pkg::LANE_W;
	localparam int E   = ftl_pkg::RESP_ERR;
	typedef enum logic [2:0] {
		W_IDLE = 3'b000, W_TAKE = 3'b001, W_LOAD = 3'b010, W_ISSUE = 3'b011,
		W_BWAIT = 3'b100, W_DRAIN = 3'b101, W_RESP = 3'b110
	} ftl_wstate_t;
	typedef enum logic [2:0] {
		R_IDLE = 3'b000, R_LOAD = 3'b001, R_ADDR = 3'b010, R_DATA = 3'b011,
		R_SEND = 3'b100, R_REJ = 3'b101
	} ftl_rstate_t;

	// address of the following beat
	function automatic logic [AW-1:0] beat_step(input ftl_pkg::ftl_areq_t a,
		input logic [AW-1:0] cur);
		logic [AW-1:0] bytes;
		logic [AW-1:0] base;
		logic [AW-1:0] win;
		bytes = AW'(1) << a.size;
		base  = cur & ~(bytes - AW'(1));
		win   = (AW'(a.len) + AW'(1)) * bytes - AW'(1);
		if (a.burst == ftl_pkg::BURST_FIXED) begin
			beat_step = cur;
		end else if (a.burst == ftl_pkg::BURST_WRAP) begin
			beat_step = (base & ~win) | ((base + bytes) & win);
		end else begin
			beat_step = base + bytes;
		end
	endfunction : beat_step

	// first lite address of a beat
	function automatic logic [AW-1:0] piece_start(input logic [2:0] size,
		input logic [AW-1:0] addr);
		if (size > ftl_pkg::LT_SIZE) begin
			piece_start = addr & ~AW'(LSW - 1);
		end else begin
			piece_start = addr;
		end
	endfunction : piece_start

	// piece ends at its beat container
	function automatic logic piece_last(input logic [2:0] size, input logic [AW-1:0] pa);
		logic [AW-1:0] bytes;
		bytes = AW'(1) << size;
		piece_last = (size <= ftl_pkg::LT_SIZE) || (((pa + AW'(LSW)) & (bytes - AW'(1))) == '0);
	endfunction : piece_last

	// outside the lite subset, and needing real conversion
	function automatic logic is_complex(input ftl_pkg::ftl_areq_t a);
		return (a.len != ftl_pkg::LEN_SINGLE) || (a.size > ftl_pkg::LT_SIZE);
	endfunction : is_complex
	function automatic logic is_nc(input ftl_pkg::ftl_areq_t a);
		return is_complex(a) || a.lock || (a.cache != ftl_pkg::CACHE_LITE)
			|| (a.size != ftl_pkg::LT_SIZE);
	endfunction : is_nc

	ftl_wstate_t         w_state;
	ftl_rstate_t         r_state;
	ftl_pkg::ftl_areq_t  w_req;
	ftl_pkg::ftl_areq_t  r_req;
	ftl_pkg::ftl_wbeat_t w_buf;
	logic [AW-1:0]       w_beat;
	logic [AW-1:0]       w_piece;
	logic [AW-1:0]       r_beat;
	logic [AW-1:0]       r_piece;
	logic [7:0]          w_left;
	logic [7:0]          r_left;
	logic [1:0]          w_acc;
	logic [1:0]          r_acc;
	logic                w_first;
	logic                r_first;
	logic                w_rej;
	logic [ftl_pkg::UP_DW-1:0] r_buf;

	// handshakes
	logic aw_take;
	logic w_take;
	logic b_done;
	logic ar_take;
	logic r_done;
	assign aw_take = s_awvalid && s_awready;
	assign w_take  = s_wvalid && s_wready;
	assign b_done  = s_bvalid && s_bready;
	assign ar_take = s_arvalid && s_arready;
	assign r_done  = s_rvalid && s_rready;

	// mode decisions per request
	logic aw_nc;
	logic ar_nc;
	logic aw_rej;
	logic ar_rej;
	assign aw_nc  = is_nc(s_aw);
	assign ar_nc  = is_nc(s_ar);
	assign aw_rej = ((mode == ftl_pkg::FTL_PROTECT) && aw_nc)
		|| ((mode == ftl_pkg::FTL_SIMPLE) && is_complex(s_aw));
	assign ar_rej = ((mode == ftl_pkg::FTL_PROTECT) && ar_nc)
		|| ((mode == ftl_pkg::FTL_SIMPLE) && is_complex(s_ar));

	// lane selection and step decode
	logic [LW-1:0]  w_lane;
	logic [LW-1:0]  r_lane;
	logic [AW-1:0]  w_next;
	logic [AW-1:0]  r_next;
	logic           w_plast;
	logic           r_plast;
	logic [ftl_pkg::UP_DW-1:0] r_buf_next;
	assign w_lane  = w_piece[LSB +: LW];
	assign r_lane  = r_piece[LSB +: LW];
	assign w_next  = beat_step(w_req, w_beat);
	assign r_next  = beat_step(r_req, r_beat);
	assign w_plast = piece_last(w_req.size, w_piece);
	assign r_plast = piece_last(r_req.size, r_piece);

	// lite read data dropped into its lane
	always_comb begin
		r_buf_next = r_buf;
		r_buf_next[r_lane*LDW +: LDW] = m_rdata;
	end

	logic [ftl_pkg::ID_W-1:0] wq_head;
	logic [ftl_pkg::ID_W-1:0] rq_head;
	logic                     wq_full;
	logic                     rq_full;
	ftl_id_queue u_wq (.clk(clk), .arst_n(arst_n), .push(aw_take), .push_id(s_aw.id),
		.full(wq_full), .pop(b_done), .head(wq_head));
	ftl_id_queue u_rq (.clk(clk), .arst_n(arst_n), .push(ar_take), .push_id(s_ar.id),
		.full(rq_full), .pop(r_done && s_rlast), .head(rq_head));

	// response folding
	logic [1:0] w_merged;
	logic [1:0] r_merged;
	ftl_resp_merge u_wm (.first(w_first), .acc(w_acc), .incoming(m_bresp), .merged(w_merged));
	ftl_resp_merge u_rm (.first(r_first), .acc(r_acc), .incoming(m_rresp), .merged(r_merged));

	// write path
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			w_state   <= W_IDLE;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bid     <= '0;
			s_bresp   <= ftl_pkg::RESP_OKAY;
			m_awvalid <= 1'b0;
			m_aw      <= '0;
			m_wvalid  <= 1'b0;
			m_wdata   <= '0;
			m_wstrb   <= '0;
			m_bready  <= 1'b0;
			w_req     <= '0;
			w_buf     <= '0;
			w_beat    <= '0;
			w_piece   <= '0;
			w_left    <= '0;
			w_acc     <= ftl_pkg::RESP_OKAY;
			w_first   <= 1'b0;
			w_rej     <= 1'b0;
		end else begin
			case (w_state)
			W_IDLE: begin
				s_awready <= !aw_take && !wq_full;
				if (aw_take) begin
					w_req    <= s_aw;
					w_beat   <= s_aw.addr;
					w_piece  <= piece_start(s_aw.size, s_aw.addr);
					w_left   <= s_aw.len;
					w_first  <= 1'b1;
					w_rej    <= aw_rej;
					s_wready <= 1'b1;
					w_state  <= aw_rej ? W_DRAIN : W_TAKE;
				end
			end
			W_TAKE: if (w_take) begin
				s_wready <= 1'b0;
				w_buf    <= s_w;
				w_state  <= W_LOAD;
			end
			W_LOAD: begin
				m_awvalid <= 1'b1;
				m_wvalid  <= 1'b1;
				m_aw      <= '{addr: w_piece, prot: w_req.prot};
				m_wdata   <= w_buf.data[w_lane*LDW +: LDW];
				m_wstrb   <= w_buf.strb[w_lane*LSW +: LSW];
				w_state   <= W_ISSUE;
			end
			W_ISSUE: begin
				if (m_awready) begin
					m_awvalid <= 1'b0;
				end
				if (m_wready) begin
					m_wvalid <= 1'b0;
				end
				if ((!m_awvalid || m_awready) && (!m_wvalid || m_wready)) begin
					m_bready <= 1'b1;
					w_state  <= W_BWAIT;
				end
			end
			W_BWAIT: if (m_bvalid) begin
				m_bready <= 1'b0;
				w_acc    <= w_merged;
				w_first  <= 1'b0;
				if (!w_plast) begin
					w_piece <= w_piece + AW'(LSW);
					w_state <= W_LOAD;
				end else if (w_left != ftl_pkg::LEN_SINGLE) begin
					w_left   <= w_left - ftl_pkg::LEN_STEP;
					w_beat   <= w_next;
					w_piece  <= piece_start(w_req.size, w_next);
					s_wready <= 1'b1;
					w_state  <= W_TAKE;
				end else begin
					s_bvalid <= 1'b1;
					s_bresp  <= w_merged;
					s_bid    <= wq_head;
					w_state  <= W_RESP;
				end
			end
			W_DRAIN: if (w_take) begin
				if (w_left == ftl_pkg::LEN_SINGLE) begin
					s_wready <= 1'b0;
					s_bvalid <= 1'b1;
					s_bresp  <= ftl_pkg::RESP_SLVERR;
					s_bid    <= wq_head;
					w_state  <= W_RESP;
				end else begin
					w_left <= w_left - ftl_pkg::LEN_STEP;
				end
			end
			W_RESP: if (b_done) begin
				s_bvalid <= 1'b0;
				w_state  <= W_IDLE;
			end
			default: w_state <= W_IDLE;
			endcase
		end
	end

	// read path
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_state   <= R_IDLE;
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rid     <= '0;
			s_rdata   <= '0;
			s_rresp   <= ftl_pkg::RESP_OKAY;
			s_rlast   <= 1'b0;
			m_arvalid <= 1'b0;
			m_ar      <= '0;
			m_rready  <= 1'b0;
			r_req     <= '0;
			r_buf     <= '0;
			r_beat    <= '0;
			r_piece   <= '0;
			r_left    <= '0;
			r_acc     <= ftl_pkg::RESP_OKAY;
			r_first   <= 1'b0;
		end else begin
			case (r_state)
			R_IDLE: begin
				s_arready <= !ar_take && !rq_full;
				if (ar_take) begin
					r_req   <= s_ar;
					r_beat  <= s_ar.addr;
					r_piece <= piece_start(s_ar.size, s_ar.addr);
					r_left  <= s_ar.len;
					r_first <= 1'b1;
					r_state <= R_LOAD;
					if (ar_rej) begin
						s_rvalid <= 1'b1;
						s_rresp  <= ftl_pkg::RESP_SLVERR;
						s_rid    <= s_ar.id;
						s_rlast  <= (s_ar.len == ftl_pkg::LEN_SINGLE);
						r_state  <= R_REJ;
					end
				end
			end
			R_LOAD: begin
				m_arvalid <= 1'b1;
				m_ar      <= '{addr: r_piece, prot: r_req.prot};
				r_state   <= R_ADDR;
			end
			R_ADDR: if (m_arready) begin
				m_arvalid <= 1'b0;
				m_rready  <= 1'b1;
				r_state   <= R_DATA;
			end
			R_DATA: if (m_rvalid) begin
				m_rready <= 1'b0;
				r_buf    <= r_buf_next;
				r_acc    <= r_merged;
				r_first  <= 1'b0;
				if (!r_plast) begin
					r_piece <= r_piece + AW'(LSW);
					r_state <= R_LOAD;
				end else begin
					s_rvalid <= 1'b1;
					s_rdata  <= r_buf_next;
					s_rresp  <= r_merged;
					s_rid    <= rq_head;
					s_rlast  <= (r_left == ftl_pkg::LEN_SINGLE);
					r_state  <= R_SEND;
				end
			end
			R_SEND: if (r_done) begin
				s_rvalid <= 1'b0;
				r_state  <= R_IDLE;
				if (r_left != ftl_pkg::LEN_SINGLE) begin
					r_left  <= r_left - ftl_pkg::LEN_STEP;
					r_beat  <= r_next;
					r_piece <= piece_start(r_req.size, r_next);
					r_first <= 1'b1;
					r_state <= R_LOAD;
				end
			end
			R_REJ: if (r_done) begin
				if (r_left == ftl_pkg::LEN_SINGLE) begin
					s_rvalid <= 1'b0;
					r_state  <= R_IDLE;
				end else begin
					r_left  <= r_left - ftl_pkg::LEN_STEP;
					s_rlast <= (r_left == ftl_pkg::LEN_STEP);
				end
			end
			default: r_state <= R_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			nc_flag <= 1'b0;
		end else begin
			nc_flag <= (mode == ftl_pkg::FTL_DETECT) && ((aw_take && aw_nc) || (ar_take && ar_nc));
		end
	end

	// checks: last accepted ids
	logic [ftl_pkg::ID_W-1:0] aw_id_seen;
	logic [ftl_pkg::ID_W-1:0] ar_id_seen;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_id_seen <= '0;
			ar_id_seen <= '0;
		end else begin
			aw_id_seen <= aw_take ? s_aw.id : aw_id_seen;
			ar_id_seen <= ar_take ? s_ar.id : ar_id_seen;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_err_beat;
		m_bvalid && m_bready && m_bresp[E];
	endsequence
	sequence s_rej_read;
		ar_take && ar_rej;
	endsequence
	a_width_order: assert property (ftl_pkg::UP_DW >= LDW)
		else $error("upstream narrower than lite side");
	a_bid_reflect: assert property (s_bvalid |-> s_bid == aw_id_seen)
		else $error("write id not reflected");
	a_rid_reflect: assert property (s_rvalid |-> s_rid == ar_id_seen)
		else $error("read id not reflected");
	a_err_sticky: assert property (s_err_beat |=> w_acc[E])
		else $error("write error lost");
	a_first_err: assert property (w_acc[E] && !w_first and s_err_beat |=> $stable(w_acc))
		else $error("later error replaced first");
	a_no_exokay: assert property (s_bvalid |-> s_bresp != ftl_pkg::RESP_EXOKAY)
		else $error("exclusive okay sent upstream");
	a_fixed_addr: assert property (m_arvalid && r_req.burst == ftl_pkg::BURST_FIXED
		&& r_req.size <= ftl_pkg::LT_SIZE |-> m_ar.addr == r_req.addr)
		else $error("fixed burst address moved");
	a_piece_align: assert property (m_awvalid && w_req.size > ftl_pkg::LT_SIZE
		|-> m_aw.addr[LSB-1:0] == '0)
		else $error("wide piece not aligned");
	a_rej_read: assert property (s_rej_read |=> s_rvalid && s_rresp == ftl_pkg::RESP_SLVERR)
		else $error("rejected read without error");
	a_rlast_count: assert property (s_rvalid |-> s_rlast == (r_left == ftl_pkg::LEN_SINGLE))
		else $error("read last on wrong beat");
	a_wrej_err: assert property (s_bvalid && w_rej |-> s_bresp == ftl_pkg::RESP_SLVERR)
		else $error("rejected write answered okay");
	a_detect_flag: assert property (ar_take && ar_nc && mode == ftl_pkg::FTL_DETECT
		|=> nc_flag ##1 1'b1 ##0 r_state != R_IDLE || s_rvalid || m_arvalid)
		else $error("detected read not flagged or dropped");
endmodule : ftl_bridge

// *** dv/ftl_lite_slave.sv ***
// Purpose: lite slave model facing the bridge
// Assumes: one transfer per direction in flight
// Notes: err_addr picks the error answer, slow stalls readies
`timescale 1ns/100ps
module ftl_lite_slave (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// behaviour control
	input  wire logic                slow,
	input  wire logic [1:0]          ok_code,
	input  wire logic [1:0]          err_code,
	input  wire logic [31:0]         err_addr,
	// write side
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire ftl_pkg::ftl_laddr_t aw,
	input  wire logic                wvalid,
	output logic                     wready,
	output logic                     bvalid,
	input  wire logic                bready,
	output logic [1:0]               bresp,
	// read side
	input  wire logic                arvalid,
	output logic                     arready,
	input  wire ftl_pkg::ftl_laddr_t ar,
	output logic                     rvalid,
	input  wire logic                rready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp
);
	logic [31:0] wa;
	logic [31:0] ra;
	logic        got_aw;
	logic        got_w;
	logic        go;
	logic [1:0]  cyc;
	// readies, stalled two of four cycles when slow
	assign go      = !slow || cyc[1];
	assign awready = go && !got_aw && !bvalid;
	assign wready  = go && !got_w && !bvalid;
	assign arready = go && !rvalid;
	// released read data shows the address xor 5A5A_0000, held data its inverse
	assign rdata   = rvalid ? (ra ^ 32'h5A5A_0000) : ~(ra ^ 32'h5A5A_0000);
	// transfer bookkeeping
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{cyc, got_aw, got_w, bvalid, rvalid, wa, ra, bresp, rresp} <= '0;
		end else begin
			cyc <= cyc + 2'h1;
			if (awvalid && awready) begin
				got_aw <= 1'b1;
				wa     <= aw.addr;
			end
			if (wvalid && wready)
				got_w <= 1'b1;
			if (got_aw && got_w && !bvalid) begin
				bvalid <= 1'b1;
				// the word after the error address answers the other error code
				bresp  <= (wa == err_addr) ? err_code
					: (wa == err_addr + 32'h4) ? (err_code ^ 2'h1) : ok_code;
				got_aw <= 1'b0;
				got_w  <= 1'b0;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				ra     <= ar.addr;
				rresp  <= (ar.addr == err_addr) ? err_code : ok_code;
			end else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end
endmodule : ftl_lite_slave

// *** dv/ftl_bridge_tb.sv ***
// Purpose: self-checking bench for the bridge
// Assumes: inputs driven on falling edges
// Notes: lite traffic logged by edge monitors
`timescale 1ns/100ps
module ftl_bridge_tb;
	logic clk = 0, arst_n = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
	logic s_arvalid = 0, s_rready = 0, nc_flag, nc_seen = 0, slow = 0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, s_rlast;
	logic m_awvalid, m_awready, m_wvalid, m_wready, m_bvalid, m_bready;
	logic m_arvalid, m_arready, m_rvalid, m_rready;
	logic [3:0] s_bid, s_rid, m_wstrb;
	logic [1:0] s_bresp, s_rresp, m_bresp, m_rresp;
	logic [1:0] ok_code = 2'h0, err_code = 2'h0;
	logic [31:0] err_addr = 32'hFFFF_FFFF, m_wdata, m_rdata;
	logic [63:0] s_rdata;
	ftl_pkg::ftl_mode_t mode = ftl_pkg::FTL_CONVERT;
	ftl_pkg::ftl_areq_t s_aw = '0, s_ar = '0;
	ftl_pkg::ftl_wbeat_t s_w = '0;
	ftl_pkg::ftl_laddr_t m_aw, m_ar, aq[$], arq[$];
	logic [3:0] sq[$];
	logic [31:0] dq[$];
	wire [4:0] rdy = {s_rvalid, s_bvalid, s_arready, s_wready, s_awready};
	int n_errors = 0, checks_done = 0;
	ftl_bridge i_ftl_bridge (.*);
	ftl_lite_slave i_ftl_lite_slave (.clk(clk), .arst_n(arst_n), .slow(slow),
		.ok_code(ok_code), .err_code(err_code), .err_addr(err_addr),
		.awvalid(m_awvalid), .awready(m_awready), .aw(m_aw), .wvalid(m_wvalid),
		.wready(m_wready), .bvalid(m_bvalid), .bready(m_bready), .bresp(m_bresp),
		.arvalid(m_arvalid), .arready(m_arready), .ar(m_ar), .rvalid(m_rvalid),
		.rready(m_rready), .rdata(m_rdata), .rresp(m_rresp));
	always #2 clk = ~clk;
	// lite transfer and detection monitors
	always @(posedge clk) begin
		if (m_awvalid && m_awready) aq.push_back(m_aw);
		if (m_wvalid && m_wready) sq.push_back(m_wstrb);
		if (m_wvalid && m_wready) dq.push_back(m_wdata);
		if (m_arvalid && m_arready) arq.push_back(m_ar);
		if (nc_flag) nc_seen = 1'b1;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic wt(input int k);
		int n;
		for (n = 0; n < 200 && rdy[k] !== 1'b1; n++) @(negedge clk);
		if (n == 200) begin
			n_errors++;
			$display("[FAIL] %0t handshake timeout %0d", $time, k);
			report_and_stop();
		end
	endtask : wt
	task automatic wr(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
		input logic [2:0] sz, input logic [1:0] bu, input logic lk, input logic [7:0] st,
		input logic [1:0] er);
		aq.delete();
		sq.delete();
		dq.delete();
		s_aw = '{id:id, addr:a, len:len, size:sz, burst:bu, lock:lk, cache:4'h0, prot:3'h5};
		s_awvalid = 1;
		wt(0);
		@(negedge clk) s_awvalid = 0;
		s_w = '{data:64'h0123_4567_89AB_CDEF, strb:st, last:1'b0};
		s_wvalid = 1;
		for (int i = 0; i <= len; i++) begin
			wt(1);
			@(negedge clk);
		end
		s_wvalid = 0;
		wt(3);
		chk(s_bid, id, "bid");
		chk(s_bresp, er, "bresp");
		s_bready = 1;
		@(negedge clk) s_bready = 0;
	endtask : wr
	task automatic rd(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
		input logic [1:0] bu, input logic [1:0] er);
		logic [31:0] ba;
		ba = a;
		arq.delete();
		s_ar = '{id:id, addr:a, len:len, size:3'h2, burst:bu, lock:0, cache:0, prot:3'h2};
		s_arvalid = 1;
		wt(2);
		@(negedge clk) s_arvalid = 0;
		s_rready = 1;
		for (int i = 0; i <= len; i++) begin
			wt(4);
			chk(s_rid, id, "rid");
			chk(s_rresp, er, "rresp");
			chk(s_rlast, i == len, "rlast");
			if (er == 2'h0) chk(s_rdata[ba[2]*32 +: 32], ba ^ 32'h5A5A_0000, "rdata");
			if (bu != 2'h0) ba = ba + 32'h4;
			@(negedge clk);
		end
		s_rready = 0;
		if (er == 2'h0) chk(arq[0], {a, 3'h2}, "lite read addr");
		else chk(arq.size(), 0, "rejected read held back");
	endtask : rd
	task automatic t_single();
		wr(4'h3, 32'h0000_0100, 8'h00, 3'h2, 2'h1, 1'b0, 8'h00, 2'h0);
		chk(aq.size(), 1, "empty strobe write");
		chk(aq[0], {32'h0000_0100, 3'h5}, "lite addr");
		chk(sq[0], 4'h0, "strobe");
		chk(nc_seen, 0, "flag in convert");
		$display("single write done");
	endtask : t_single
	task automatic t_burst();
		slow = 1;
		err_addr = 32'h0000_0104;
		err_code = 2'h2;
		wr(4'hA, 32'h0000_0102, 8'h02, 3'h2, 2'h1, 1'b0, 8'hFF, 2'h2);
		chk(aq.size(), 3, "beats");
		chk(aq[1].addr, 32'h0000_0104, "incr beat 1");
		chk(aq[2].addr, 32'h0000_0108, "incr beat 2");
		wr(4'hB, 32'h0000_0110, 8'h01, 3'h2, 2'h0, 1'b0, 8'hFF, 2'h0);
		chk(aq[1].addr, 32'h0000_0110, "fixed beat");
		wr(4'hD, 32'h0000_0118, 8'h03, 3'h2, 2'h2, 1'b0, 8'hFF, 2'h0);
		chk(aq[2].addr, 32'h0000_0110, "wrap beat 2");
		err_code = 2'h3;
		wr(4'hC, 32'h0000_0104, 8'h01, 3'h2, 2'h1, 1'b0, 8'hFF, 2'h3);
		slow = 0;
		$display("burst write done");
	endtask : t_burst
	task automatic t_wide();
		wr(4'h6, 32'h0000_0200, 8'h00, 3'h3, 2'h1, 1'b0, 8'h3C, 2'h0);
		chk(aq[1].addr, 32'h0000_0204, "wide piece");
		chk({sq[0], sq[1]}, 8'hC3, "wide strobes");
		chk({dq[1], dq[0]}, 64'h0123_4567_89AB_CDEF, "wide data");
		wr(4'h6, 32'h0000_0205, 8'h00, 3'h0, 2'h1, 1'b0, 8'h20, 2'h0);
		chk(aq[0].addr, 32'h0000_0205, "narrow addr");
		chk({sq[0], dq[0]}, {4'h2, 32'h0123_4567}, "narrow lane");
		$display("wide write done");
	endtask : t_wide
	task automatic t_excl();
		mode = ftl_pkg::FTL_DETECT;
		ok_code = 2'h1;
		wr(4'h9, 32'h0000_0300, 8'h00, 3'h2, 2'h1, 1'b1, 8'h0F, 2'h0);
		chk(nc_seen, 1, "detect flag");
		chk(aq.size(), 1, "detect forwards");
		ok_code = 2'h0;
		$display("exclusive write done");
	endtask : t_excl
	task automatic t_protect();
		mode = ftl_pkg::FTL_SIMPLE;
		wr(4'h2, 32'h0000_0500, 8'h00, 3'h2, 2'h1, 1'b1, 8'h0F, 2'h0);
		chk(aq.size(), 1, "simple forwards lock");
		wr(4'h4, 32'h0000_0500, 8'h01, 3'h2, 2'h1, 1'b0, 8'h0F, 2'h2);
		chk(aq.size(), 0, "simple drops burst");
		mode = ftl_pkg::FTL_PROTECT;
		wr(4'h8, 32'h0000_0504, 8'h00, 3'h2, 2'h1, 1'b1, 8'h0F, 2'h2);
		chk(aq.size(), 0, "protect drops lock");
		$display("protection writes done");
	endtask : t_protect
	task automatic t_read();
		mode = ftl_pkg::FTL_CONVERT;
		rd(4'h5, 32'h0000_0304, 8'h00, 2'h1, 2'h0);
		rd(4'h1, 32'h0000_0304, 8'h01, 2'h0, 2'h0);
		mode = ftl_pkg::FTL_DETECT;
		nc_seen = 0;
		rd(4'h2, 32'h0000_0600, 8'h01, 2'h1, 2'h0);
		chk(nc_seen, 1, "read detect flag");
		mode = ftl_pkg::FTL_PROTECT;
		rd(4'h7, 32'h0000_0400, 8'h01, 2'h1, 2'h2);
		$display("reads done");
	endtask : t_read
	initial begin
		repeat (10) @(negedge clk);
		arst_n = 1;
		@(negedge clk);
		t_single();
		t_burst();
		t_wide();
		t_excl();
		t_protect();
		t_read();
		report_and_stop();
	end
endmodule : ftl_bridge_tb
